// ### core/spdf_framer.sv
/*
 one serial port in protocol-free mode: framed transmit of buffered
 words, delimited reception into a byte buffer, copy-out to words.
 assumes a single-master register port on sys_clk and asynchronous
 serial pins, which pass a two-flop synchroniser here.
*/
// Overview of operation
// - port works only while setup mode field holds 1
// - delimiter word holds start code and end code or count, 00=256
// - one operation carries at most 259 bytes including codes
// - only the first start code opens; later ones are data
// - the first end code closes the frame
// - payload limits 256/257/258/259 follow from the delimiting; code caps tx at 256, rx at 259
// - byte order field picks leftmost or rightmost byte first
// - transmit modem field drives rts/dtr from first word bits
// - receive modem field copies cts/dsr into first stored word
// - port field picks port; board field only when port field 0
// - transmit count is four-digit bcd, 0000 to 0256
// - transmit ready low from start until last byte sent
// - receive copies bytes without codes, then clears complete
// - accept always without start code, else after it arrives
// - frame ends on end code or after 259 bytes
// - bcd error code 0..3 plus a communications error flag
// - error code and status cleared on each receive command
// - overrun flag when a byte arrives before readout
// - received byte count excludes codes, in its own word
// - port reset bit reinitialises port, then clears itself
`timescale 1ns/10ps
`default_nettype none
`include "spdf_map.svh"
module spdf_framer #(
	parameter int CLK_HZ = `SPDF_CLK_HZ,
	parameter logic [3:0] PORT_SEL = 4'h0,
	parameter logic [3:0] BOARD_SEL = 4'h0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [10:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic ser_rxd,
	input wire logic ser_cts,
	input wire logic ser_dsr,
	output logic ser_txd,
	output logic ser_rts,
	output logic ser_dtr
);
	// ------------------------------------------------------------
	// rates
	// ------------------------------------------------------------
	localparam int OV = `SPDF_OVS;
	localparam int DV0 = CLK_HZ / (`SPDF_BAUD0 * OV);
	localparam int DV1 = CLK_HZ / (`SPDF_BAUD1 * OV);
	localparam int DV2 = CLK_HZ / (`SPDF_BAUD2 * OV);
	localparam int DV3 = CLK_HZ / (`SPDF_BAUD3 * OV);
	localparam int DV4 = CLK_HZ / (`SPDF_BAUD4 * OV);
	if (DV4 < 2 || DV0 > 65535) begin : g_chk
		$error("clock rate cannot serve the baud table");
	end

	logic [31:0] setup_q, delim_q;
	logic prst_q, ref_q;
	logic [15:0] dc_q;
	logic rxd_m_q, rxd_q, cts_m_q, cts_q, dsr_m_q, dsr_q;

	// ------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------
	wire clr = prst_q;
	wire mode_on = setup_q[`SPDF_S_MODE] == `SPDF_MODE_FREE;
	wire [3:0] bd = setup_q[`SPDF_S_BAUD];
	wire [15:0] dv = (bd == 4'h0) ? 16'(DV0) : (bd == 4'h1) ? 16'(DV1) :
		(bd == 4'h2) ? 16'(DV2) : (bd == 4'h3) ? 16'(DV3) : 16'(DV4);
	wire tick = dc_q == 16'h0000;
	wire [3:0] fmt = setup_q[`SPDF_S_FMT];
	wire len7 = fmt < 4'h6;
	wire [2:0] sub = len7 ? fmt[2:0] : 3'(fmt - 4'h6);
	wire two_st = sub >= 3'h3;
	wire [2:0] psel = two_st ? 3'(sub - 3'h3) : sub;
	wire par_en = psel != 3'h2;
	wire par_odd = psel == 3'h1;
	// bits per character, start through last stop
	wire [3:0] nb = 4'h1 + (len7 ? 4'h7 : 4'h8) + {3'h0, par_en} +
		(two_st ? 4'h2 : 4'h1);
	wire sten = delim_q[`SPDF_D_STEN];
	wire [1:0] endm = delim_q[`SPDF_D_ENDM];
	wire [7:0] stc = delim_q[`SPDF_D_STC];
	wire [7:0] endc = delim_q[`SPDF_D_ENDC];
	wire [8:0] nmax = (endc == 8'h00) ? 9'd256 : {1'b0, endc};

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire [15:0] ctl = bus_wdata[15:0];
	wire [15:0] bcd = bus_wdata[31:16];
	wire pmatch = ctl[`SPDF_C_PORT] == PORT_SEL && (PORT_SEL != 4'h0 ||
		ctl[`SPDF_C_BRD] == BOARD_SEL);
	wire [8:0] tbin = 9'(bcd[11:8]) * 9'd100 + 9'(bcd[7:4]) * 9'd10 +
		9'(bcd[3:0]);
	// hundreds digit above 4 can wrap the 9-bit binary count
	wire bcd_ok = bcd[15:12] == 4'h0 && bcd[11:8] <= 4'h2 &&
		bcd[7:4] <= 4'h9 && bcd[3:0] <= 4'h9 && tbin <= `SPDF_TX_MAX;
	wire tx_wr = bus_wr && bus_addr == `SPDF_A_TXCMD;
	wire rx_wr = bus_wr && bus_addr == `SPDF_A_RXCMD;

	// ------------------------------------------------------------
	// synchronisers and oversample divider
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rxd_m_q <= 1'b1;
			rxd_q <= 1'b1;
			cts_m_q <= 1'b0;
			cts_q <= 1'b0;
			dsr_m_q <= 1'b0;
			dsr_q <= 1'b0;
		end else begin
			rxd_m_q <= ser_rxd;
			rxd_q <= rxd_m_q;
			cts_m_q <= ser_cts;
			cts_q <= cts_m_q;
			dsr_m_q <= ser_dsr;
			dsr_q <= dsr_m_q;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			dc_q <= 16'h0000;
		else
			dc_q <= tick ? 16'(dv - 16'h0001) : 16'(dc_q - 16'h0001);
	end

	// ------------------------------------------------------------
	// transmit sequencer and shifter
	// ------------------------------------------------------------
	logic [15:0] txm [0:`SPDF_TXW-1];
	spdf_pkg::spdf_tx_t ts_q;
	logic [8:0] tcnt_q;
	logic [7:0] ti_q;
	logic tord_q, trdy_q, txd_q, rts_q, dtr_q;
	logic [10:0] tsh_q;
	logic [3:0] tbits_q, tph_q;

	wire tx_go = tx_wr && pmatch && bcd_ok && trdy_q && mode_on && !clr;
	wire [15:0] tw = txm[ti_q[7:1]];
	wire [7:0] tb = (ti_q[0] ^ tord_q) ? tw[7:0] : tw[15:8];
	wire t_crlf = endm == `SPDF_END_CRLF;
	wire [7:0] tbyte = (ts_q == spdf_pkg::TS_STC) ? stc :
		(ts_q == spdf_pkg::TS_DATA) ? tb :
		(ts_q == spdf_pkg::TS_END1) ? (t_crlf ? `SPDF_CR : endc) :
		`SPDF_LF;
	wire tdone = ts_q == spdf_pkg::TS_DATA && tcnt_q == 9'd0;
	wire tload = tbits_q == 4'h0 && ts_q != spdf_pkg::TS_IDLE && !tdone;
	wire tpar = !par_en ||
		(par_odd ^ (len7 ? ^tbyte[6:0] : ^tbyte));
	wire [11:0] tfr = len7 ? {3'h7, tpar, tbyte[6:0], 1'b0} :
		{2'h3, tpar, tbyte, 1'b0};

	always_ff @(posedge sys_clk) begin
		if (bus_wr && bus_addr[10:9] == `SPDF_A_TXWIN)
			txm[bus_addr[8:2]] <= bus_wdata[15:0];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ts_q <= spdf_pkg::TS_IDLE;
			tcnt_q <= 9'd0;
			ti_q <= 8'h00;
			tord_q <= 1'b0;
			trdy_q <= 1'b1;
			rts_q <= 1'b0;
			dtr_q <= 1'b0;
		end else if (clr) begin
			ts_q <= spdf_pkg::TS_IDLE;
			tcnt_q <= 9'd0;
			trdy_q <= 1'b1;
			rts_q <= 1'b0;
			dtr_q <= 1'b0;
		end else if (tx_go) begin
			trdy_q <= 1'b0;
			tcnt_q <= tbin;
			ti_q <= 8'h00;
			tord_q <= ctl[`SPDF_C_ORD] == 4'h1;
			ts_q <= sten ? spdf_pkg::TS_STC : spdf_pkg::TS_DATA;
			case (ctl[`SPDF_C_MDM])
			4'h1: rts_q <= txm[0][15];
			4'h2: dtr_q <= txm[0][15];
			4'h3: begin
				rts_q <= txm[0][14];
				dtr_q <= txm[0][15];
			end
			default: ;
			endcase
		end else begin
			case (ts_q)
			spdf_pkg::TS_STC:
				if (tload)
					ts_q <= spdf_pkg::TS_DATA;
			spdf_pkg::TS_DATA:
				if (tdone)
					ts_q <= (endm == `SPDF_END_CNT) ?
						spdf_pkg::TS_IDLE : spdf_pkg::TS_END1;
				else if (tload) begin
					tcnt_q <= 9'(tcnt_q - 9'd1);
					ti_q <= 8'(ti_q + 8'h01);
				end
			spdf_pkg::TS_END1:
				if (tload)
					ts_q <= t_crlf ? spdf_pkg::TS_END2 : spdf_pkg::TS_IDLE;
			spdf_pkg::TS_END2:
				if (tload)
					ts_q <= spdf_pkg::TS_IDLE;
			default:
				if (tbits_q == 4'h0)
					trdy_q <= 1'b1;
			endcase
		end
	end

	// line stays marking while idle; stop bits come from the frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tsh_q <= 11'h7ff;
			tbits_q <= 4'h0;
			tph_q <= 4'h0;
			txd_q <= 1'b1;
		end else if (clr) begin
			tbits_q <= 4'h0;
			txd_q <= 1'b1;
		end else if (tload) begin
			tsh_q <= tfr[11:1];
			txd_q <= tfr[0];
			tbits_q <= nb;
			tph_q <= 4'h0;
		end else if (tick && tbits_q != 4'h0) begin
			tph_q <= 4'(tph_q + 4'h1);
			if (tph_q == 4'hf) begin
				tbits_q <= 4'(tbits_q - 4'h1);
				txd_q <= (tbits_q == 4'h1) ? 1'b1 : tsh_q[0];
				tsh_q <= {1'b1, tsh_q[10:1]};
			end
		end
	end

	// ------------------------------------------------------------
	// character receiver
	// ------------------------------------------------------------
	spdf_pkg::spdf_rb_t rb_q;
	logic [3:0] rph_q, rbit_q;
	logic [11:0] rsh_q;
	logic rdone_q;

	wire [7:0] rdat = len7 ? {1'b0, rsh_q[7:1]} : rsh_q[8:1];
	wire rpar = len7 ? rsh_q[8] : rsh_q[9];
	wire [3:0] s1 = len7 ? 4'(4'h8 + {3'h0, par_en}) :
		4'(4'h9 + {3'h0, par_en});
	wire ferr = !rsh_q[s1] || (two_st && !rsh_q[4'(s1 + 4'h1)]);
	wire perr = par_en && (rpar != (par_odd ^ ^rdat));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rb_q <= spdf_pkg::RB_IDLE;
			rph_q <= 4'h0;
			rbit_q <= 4'h0;
			rsh_q <= 12'hfff;
			rdone_q <= 1'b0;
		end else begin
			rdone_q <= 1'b0;
			if (clr)
				rb_q <= spdf_pkg::RB_IDLE;
			else if (tick) begin
				case (rb_q)
				spdf_pkg::RB_BITS: begin
					rph_q <= 4'(rph_q + 4'h1);
					// sample mid-bit; a short start glitch is dropped
					if (rph_q == 4'h7) begin
						rsh_q[rbit_q] <= rxd_q;
						if (rbit_q == 4'h0 && rxd_q)
							rb_q <= spdf_pkg::RB_IDLE;
						else if (rbit_q == 4'(nb - 4'h1)) begin
							rb_q <= spdf_pkg::RB_IDLE;
							rdone_q <= 1'b1;
						end else
							rbit_q <= 4'(rbit_q + 4'h1);
					end
				end
				default:
					if (!rxd_q) begin
						rb_q <= spdf_pkg::RB_BITS;
						rph_q <= 4'h0;
						rbit_q <= 4'h0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// frame collector
	// ------------------------------------------------------------
	logic [7:0] rbuf [0:258];
	spdf_pkg::spdf_col_t cs_q;
	spdf_pkg::spdf_cp_t cp_q;
	logic [8:0] cnt_q, ci_q;
	logic pcr_q, rdy_q, ovr_q, cerr_q, cord_q;
	logic [3:0] code_q, cmod_q;

	wire ev = rdone_q && mode_on && !clr;
	wire ev_ovr = ev && rdy_q;
	wire take = ev && !rdy_q && (cs_q == spdf_pkg::CS_TAKE ||
		(cs_q == spdf_pkg::CS_HUNT && !sten));
	wire hunt_hit = ev && !rdy_q && cs_q == spdf_pkg::CS_HUNT && sten &&
		rdat == stc;
	wire is_end = endm == `SPDF_END_CODE && rdat == endc;
	wire is_lf = endm == `SPDF_END_CRLF && rdat == `SPDF_LF && pcr_q;
	wire store = take && !is_end && !is_lf;
	// a new frame restarts at slot 0, whatever the last count was
	wire [8:0] cbase = (cs_q == spdf_pkg::CS_HUNT) ? 9'd0 : cnt_q;
	wire [8:0] cnt_n = 9'(cbase + 9'd1);
	wire full = (endm == `SPDF_END_CNT && cnt_n == nmax) ||
		cnt_n == `SPDF_RX_MAX;
	wire rx_go = rx_wr && pmatch && mode_on && rdy_q && !clr &&
		cp_q == spdf_pkg::CP_IDLE;
	wire cp_end = cp_q == spdf_pkg::CP_MDM;
	wire [3:0] ecode = ev_ovr ? `SPDF_ERR_OVR : (take && perr) ?
		`SPDF_ERR_PAR : (take && ferr) ? `SPDF_ERR_FRM : 4'h0;

	always_ff @(posedge sys_clk) begin
		if (store)
			rbuf[cbase] <= rdat;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_q <= spdf_pkg::CS_HUNT;
			cnt_q <= 9'd0;
			pcr_q <= 1'b0;
			rdy_q <= 1'b0;
		end else if (clr || cp_end) begin
			cs_q <= spdf_pkg::CS_HUNT;
			pcr_q <= 1'b0;
			rdy_q <= 1'b0;
			if (clr)
				cnt_q <= 9'd0;
		end else if (hunt_hit) begin
			cs_q <= spdf_pkg::CS_TAKE;
			cnt_q <= 9'd0;
		end else if (take) begin
			if (cs_q == spdf_pkg::CS_HUNT)
				cnt_q <= 9'd0;
			pcr_q <= store && rdat == `SPDF_CR;
			if (is_end || is_lf || (store && full)) begin
				cs_q <= spdf_pkg::CS_FULL;
				rdy_q <= 1'b1;
			end else
				cs_q <= spdf_pkg::CS_TAKE;
			if (is_lf)
				cnt_q <= 9'(cnt_q - 9'd1);
			else if (store)
				cnt_q <= cnt_n;
		end else if (hunt_hit == 1'b0 && ev && cs_q == spdf_pkg::CS_HUNT)
			cnt_q <= 9'd0;
	end

	// a new error wins over a same-cycle receive command clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			code_q <= 4'h0;
			cerr_q <= 1'b0;
			ovr_q <= 1'b0;
		end else if (clr) begin
			code_q <= 4'h0;
			cerr_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (ecode != 4'h0 && (code_q == 4'h0 || rx_go))
				code_q <= ecode;
			else if (rx_go)
				code_q <= 4'h0;
			cerr_q <= (ecode != 4'h0) || (cerr_q && !rx_go);
			ovr_q <= ev_ovr || (ovr_q && !rx_go);
		end
	end

	// ------------------------------------------------------------
	// copy-out to destination words
	// ------------------------------------------------------------
	logic [15:0] dst [0:`SPDF_RXW-1];
	wire [7:0] cb = rbuf[ci_q];
	wire [15:0] cw = dst[ci_q[8:1]];
	wire [15:0] cwv = !ci_q[0] ? (cord_q ? {8'h00, cb} : {cb, 8'h00}) :
		(cord_q ? {cb, cw[7:0]} : {cw[15:8], cb});
	wire [15:0] d0 = dst[0];
	wire [15:0] mdw = (cmod_q == 4'h1) ? {cts_q, d0[14:0]} :
		(cmod_q == 4'h2) ? {dsr_q, d0[14:0]} :
		(cmod_q == 4'h3) ? {dsr_q, cts_q, d0[13:0]} : d0;
	wire cp_mv = cp_q == spdf_pkg::CP_MOVE && ci_q != cnt_q;

	always_ff @(posedge sys_clk) begin
		if (cp_mv)
			dst[ci_q[8:1]] <= cwv;
		else if (cp_end)
			dst[0] <= mdw;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cp_q <= spdf_pkg::CP_IDLE;
			ci_q <= 9'd0;
			cord_q <= 1'b0;
			cmod_q <= 4'h0;
		end else if (clr)
			cp_q <= spdf_pkg::CP_IDLE;
		else if (rx_go) begin
			cp_q <= spdf_pkg::CP_MOVE;
			ci_q <= 9'd0;
			cord_q <= ctl[`SPDF_C_ORD] == 4'h1;
			cmod_q <= ctl[`SPDF_C_MDM];
		end else if (cp_mv)
			ci_q <= 9'(ci_q + 9'd1);
		else if (cp_q == spdf_pkg::CP_MOVE)
			cp_q <= spdf_pkg::CP_MDM;
		else if (cp_end)
			cp_q <= spdf_pkg::CP_IDLE;
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	wire [31:0] stat = {23'h0, ref_q, ovr_q, rdy_q, trdy_q, cerr_q,
		code_q};
	wire rxw_hit = bus_addr[10] == `SPDF_A_RXWIN &&
		bus_addr[9:2] < 8'(`SPDF_RXW);
	wire [31:0] rv = (bus_addr == `SPDF_A_SETUP) ? setup_q :
		(bus_addr == `SPDF_A_DELIM) ? delim_q :
		(bus_addr == `SPDF_A_STAT) ? stat :
		(bus_addr == `SPDF_A_RXCNT) ? {23'h0, cnt_q} :
		(bus_addr == `SPDF_A_PRST) ? {31'h0, prst_q} :
		(bus_addr[10:9] == `SPDF_A_TXWIN) ?
			{16'h0, txm[bus_addr[8:2]]} :
		rxw_hit ? {16'h0, dst[bus_addr[9:2]]} : 32'h0;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			setup_q <= `SPDF_SETUP_RST;
			delim_q <= `SPDF_DELIM_RST;
			prst_q <= 1'b0;
			ref_q <= 1'b0;
			bus_rdata <= 32'h0;
		end else begin
			bus_rdata <= bus_rd ? rv : 32'h0;
			if (bus_wr && bus_addr == `SPDF_A_SETUP)
				setup_q <= bus_wdata;
			if (bus_wr && bus_addr == `SPDF_A_DELIM)
				delim_q <= bus_wdata;
			// reset bit holds one cycle, then drops by itself
			prst_q <= bus_wr && bus_addr == `SPDF_A_PRST &&
				bus_wdata[0] && !prst_q;
			if (tx_wr)
				ref_q <= !tx_go;
			else if (rx_wr)
				ref_q <= !rx_go;
			else if (clr)
				ref_q <= 1'b0;
		end
	end

	assign ser_txd = txd_q;
	assign ser_rts = rts_q;
	assign ser_dtr = dtr_q;
endmodule
`default_nettype wire

// ### core/spdf_map.svh
/*
 map of the delimited serial framer: register offsets, field
 positions, reset values and timing figures. assumes inclusion by
 its bare name from the core and bench files.
*/
`ifndef SPDF_MAP_SVH
`define SPDF_MAP_SVH
// ----------------------------------------------------------------
// clock and line rates
// ----------------------------------------------------------------
`define SPDF_CLK_HZ 100000000
`define SPDF_OVS 16
`define SPDF_BAUD0 1200
`define SPDF_BAUD1 2400
`define SPDF_BAUD2 4800
`define SPDF_BAUD3 9600
`define SPDF_BAUD4 19200
// ----------------------------------------------------------------
// register offsets (byte addresses, 11-bit)
// ----------------------------------------------------------------
`define SPDF_A_SETUP 11'h000
`define SPDF_A_DELIM 11'h004
`define SPDF_A_TXCMD 11'h008
`define SPDF_A_RXCMD 11'h00c
`define SPDF_A_STAT 11'h010
`define SPDF_A_RXCNT 11'h014
`define SPDF_A_PRST 11'h018
`define SPDF_A_TXWIN 2'h1
`define SPDF_A_RXWIN 1'h1
// ----------------------------------------------------------------
// fields, sizes and reset values
// ----------------------------------------------------------------
`define SPDF_S_MODE 15:12
`define SPDF_S_BAUD 11:8
`define SPDF_S_FMT 3:0
`define SPDF_D_ENDC 7:0
`define SPDF_D_STC 15:8
`define SPDF_D_STEN 16
`define SPDF_D_ENDM 18:17
`define SPDF_C_ORD 3:0
`define SPDF_C_MDM 7:4
`define SPDF_C_BRD 11:8
`define SPDF_C_PORT 15:12
`define SPDF_MODE_FREE 4'h1
`define SPDF_END_CNT 2'h0
`define SPDF_END_CODE 2'h1
`define SPDF_END_CRLF 2'h2
`define SPDF_CR 8'h0d
`define SPDF_LF 8'h0a
`define SPDF_ERR_PAR 4'h1
`define SPDF_ERR_FRM 4'h2
`define SPDF_ERR_OVR 4'h3
`define SPDF_TXW 128
`define SPDF_RXW 130
`define SPDF_RX_MAX 9'd259
`define SPDF_TX_MAX 9'd256
`define SPDF_SETUP_RST 32'h0000_0303
`define SPDF_DELIM_RST 32'h0000_0000
`endif

// ### core/spdf_pkg.sv
/*
 state types of the delimited serial framer.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package spdf_pkg;
	typedef enum logic [4:0] {
		TS_IDLE = 5'h01, TS_STC = 5'h02, TS_DATA = 5'h04,
		TS_END1 = 5'h08, TS_END2 = 5'h10
	} spdf_tx_t;
	typedef enum logic [1:0] {RB_IDLE = 2'h1, RB_BITS = 2'h2} spdf_rb_t;
	typedef enum logic [2:0] {
		CS_HUNT = 3'h1, CS_TAKE = 3'h2, CS_FULL = 3'h4
	} spdf_col_t;
	typedef enum logic [2:0] {
		CP_IDLE = 3'h1, CP_MOVE = 3'h2, CP_MDM = 3'h4
	} spdf_cp_t;
endpackage
`default_nettype wire

// ### bench/spdf_framer_monitor.sv
/*
 port checker of the delimited serial framer.
 assumes it is bound onto spdf_framer and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spdf_map.svh"
module spdf_framer_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [10:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic ser_rxd,
	input wire logic ser_cts,
	input wire logic ser_dsr,
	input wire logic ser_txd,
	input wire logic ser_rts,
	input wire logic ser_dtr
);
	// ----------------------------------------------------------------
	// shadow state and assertions
	// ----------------------------------------------------------------
	logic [15:0] setup_q;
	logic seen_q;
	logic [2:0] age_q;
	wire cmd_wr = bus_wr && bus_addr == `SPDF_A_TXCMD;
	wire prst_wr = bus_wr && bus_addr == `SPDF_A_PRST;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			setup_q <= 16'(`SPDF_SETUP_RST);
			seen_q <= 1'b0;
			age_q <= 3'h7;
		end else begin
			if (bus_wr && bus_addr == `SPDF_A_SETUP) begin
				setup_q <= bus_wdata[15:0];
			end
			seen_q <= (seen_q || cmd_wr) && !prst_wr;
			age_q <= (cmd_wr || prst_wr) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
		end
	end
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_lines_reset: assert property ($fell(rst) |-> ser_txd && !ser_rts && !ser_dtr)
		else $error("serial lines not idle after reset");
	a_txd_cmd: assert property ($fell(ser_txd) |-> seen_q)
		else $error("transmit line left idle without command");
	a_modem_cmd: assert property ($changed(ser_rts) || $changed(ser_dtr) |-> age_q < 3'h4)
		else $error("modem line moved without command");
	a_setup_echo: assert property ($past(bus_rd && bus_addr == `SPDF_A_SETUP) |-> bus_rdata[15:0] == $past(setup_q))
		else $error("setup word readback wrong");
	a_unmapped_zero: assert property ($past(bus_rd && bus_addr > 11'h01b && bus_addr < 11'h200) |-> bus_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_prst_selfclr: assert property ($past(bus_rd && bus_addr == `SPDF_A_PRST) && !$past(prst_wr, 2) && !$past(prst_wr, 3) |-> !bus_rdata[0])
		else $error("port reset bit stuck");
	a_count_range: assert property ($past(bus_rd && bus_addr == `SPDF_A_RXCNT) |-> bus_rdata <= 32'd259)
		else $error("received count above limit");
	a_err_bcd: assert property ($past(bus_rd && bus_addr == `SPDF_A_STAT) |-> bus_rdata[3:0] <= 4'h3)
		else $error("error code out of range");
endmodule
`default_nettype wire

// ### bench/spdf_peer.sv
/*
 external serial device: 8 data bits, no parity, one stop, lsb first.
 assumes the framer runs at 19200 baud; BITC is clocks per bit.
*/
`timescale 1ns/10ps
`default_nettype none
module spdf_peer #(
	parameter int BITC = 32
) (
	input wire logic sys_clk,
	input wire logic line_in,
	output logic line_out,
	output logic cts,
	output logic dsr
);
	// ----------------------------------------------------------------
	// sender and listener
	// ----------------------------------------------------------------
	logic [7:0] got[$];
	logic [7:0] sh;
	initial begin
		line_out = 1'b1;
		cts = 1'b0;
		dsr = 1'b0;
	end
	task automatic set_lines(input logic c, input logic d);
		@(posedge sys_clk);
		cts <= c;
		dsr <= d;
	endtask
	// stop low on request only, to provoke a framing fault
	task automatic send(input logic [7:0] b, input logic stop);
		repeat (2 * BITC) @(posedge sys_clk);
		line_out <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (BITC) @(posedge sys_clk);
			line_out <= b[i];
		end
		repeat (BITC) @(posedge sys_clk);
		line_out <= stop;
		repeat (BITC) @(posedge sys_clk);
		line_out <= 1'b1;
	endtask
	always begin
		@(negedge line_in);
		repeat (BITC / 2) @(posedge sys_clk);
		for (int k = 0; k < 8; k++) begin
			repeat (BITC) @(posedge sys_clk);
			sh[k] = line_in;
		end
		repeat (BITC) @(posedge sys_clk);
		got.push_back(sh);
	end
endmodule
`default_nettype wire

// ### bench/spdf_framer_tb.sv
/*
 testbench of the delimited serial framer over its register port.
 assumes spdf_framer, spdf_peer and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spdf_map.svh"
module spdf_framer_tb;
	// ----------------------------------------------------------------
	// harness, tasks, scenarios
	// ----------------------------------------------------------------
	// shortest legal divider keeps frames short: 32 clocks per bit
	localparam int HZ = 614400;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [10:0] bus_addr = 11'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [31:0] bus_rdata;
	logic ser_txd, ser_rts, ser_dtr, ser_rxd, ser_cts, ser_dsr;
	logic [31:0] rv;
	logic [31:0] bad[5] = '{32'h0257_0000, 32'h001a_0000, 32'h0001_1000,
		32'h0001_0100, 32'h0700_0000};
	logic [7:0] txe[6] = '{8'h02, 8'h81, 8'h42, 8'h43, 8'h0d, 8'h0a};
	logic [7:0] rxs[5] = '{8'h55, 8'h02, 8'h02, 8'h11, 8'h03};
	int mismatches = 0;
	int n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	spdf_framer #(.CLK_HZ(HZ)) u_spdf_framer (.sys_clk(sys_clk), .rst(rst),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .ser_rxd(ser_rxd),
		.ser_cts(ser_cts), .ser_dsr(ser_dsr), .ser_txd(ser_txd),
		.ser_rts(ser_rts), .ser_dtr(ser_dtr));
	spdf_peer #(.BITC(HZ / 19200)) u_spdf_peer (.sys_clk(sys_clk),
		.line_in(ser_txd), .line_out(ser_rxd), .cts(ser_cts), .dsr(ser_dsr));
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rc(input logic [10:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 rv = bus_rdata;
		chk($sformatf("reg %h", a), e, rv & m);
	endtask
	task automatic wait_stat(input int b);
		int i;
		i = 0;
		rv = 32'h0;
		while (rv[b] !== 1'b1) begin
			rc(`SPDF_A_STAT, 32'h0, 32'h0);
			i++;
			if (i > 3000) begin
				mismatches++;
				$display("[ERR] status bit %0d expected 1 seen %b", b, rv[b]);
				complete_run();
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rc(`SPDF_A_SETUP, 32'hffff_ffff, 32'h0000_0303);
		rc(`SPDF_A_STAT, 32'h1e0, 32'h020);
		wr(`SPDF_A_TXCMD, 32'h0001_0000);
		rc(`SPDF_A_STAT, 32'h120, 32'h120);
		wr(`SPDF_A_SETUP, 32'h0000_1408);
		for (int i = 0; i < 5; i++) begin
			wr(`SPDF_A_PRST, 32'h1);
			wr(`SPDF_A_TXCMD, bad[i]);
			rc(`SPDF_A_STAT, 32'h120, 32'h120);
		end
		wr(`SPDF_A_PRST, 32'h1);
		rc(`SPDF_A_PRST, 32'h1, 32'h0);
		rc(`SPDF_A_STAT, 32'h1a0, 32'h020);
		rc(`SPDF_A_SETUP, 32'hffff, 32'h1408);
		rc(11'h100, 32'hffff_ffff, 32'h0);
		wr(`SPDF_A_DELIM, 32'h0005_0200);
		wr(11'h200, 32'h8142);
		wr(11'h204, 32'h4300);
		wr(`SPDF_A_TXCMD, 32'h0003_0030);
		rc(`SPDF_A_STAT, 32'h20, 32'h0);
		wait_stat(5);
		chk("sent bytes", 32'd6, u_spdf_peer.got.size());
		for (int i = 0; i < 6; i++) begin
			chk("sent byte", {24'h0, txe[i]}, {24'h0, u_spdf_peer.got[i]});
		end
		chk("rts dtr", 32'h1, {30'h0, ser_rts, ser_dtr});
		// end code 03 closes this payload; the second 02 is data
		wr(`SPDF_A_DELIM, 32'h0003_0203);
		u_spdf_peer.set_lines(1'b1, 1'b0);
		for (int i = 0; i < 5; i++) begin
			u_spdf_peer.send(rxs[i], 1'b1);
		end
		wait_stat(6);
		rc(`SPDF_A_RXCNT, 32'h1ff, 32'h2);
		rc(`SPDF_A_STAT, 32'hff, 32'h60);
		u_spdf_peer.send(8'h44, 1'b1);
		rc(`SPDF_A_STAT, 32'h8f, 32'h83);
		wr(`SPDF_A_RXCMD, 32'h0000_0031);
		repeat (8) @(posedge sys_clk);
		rc(`SPDF_A_STAT, 32'hcf, 32'h0);
		rc(11'h400, 32'hffff, 32'h5102);
		wr(`SPDF_A_DELIM, 32'h0002_0003);
		wr(`SPDF_A_PRST, 32'h1);
		u_spdf_peer.send(8'h41, 1'b0);
		u_spdf_peer.send(8'h03, 1'b1);
		wait_stat(6);
		rc(`SPDF_A_STAT, 32'h1f, 32'h12);
		wr(`SPDF_A_RXCMD, 32'h0);
		repeat (8) @(posedge sys_clk);
		rc(`SPDF_A_STAT, 32'h5f, 32'h0);
		rc(11'h400, 32'hffff, 32'h4100);
		complete_run();
	end
endmodule
bind spdf_framer spdf_framer_monitor u_spdf_framer_monitor (
	.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .ser_rxd(ser_rxd), .ser_cts(ser_cts),
	.ser_dsr(ser_dsr), .ser_txd(ser_txd), .ser_rts(ser_rts),
	.ser_dtr(ser_dtr));
`default_nettype wire
